// ==== include/rfc_pkg.sv ====
// Package with the constants shared by the ROM/Flash chip-select interface.
// Functional notes
// - Boot select output is active low and selects the startup ROM array.
// - Boot select asserts for any access in the fixed boot-vector segment.
// - Boot select also asserts for a software-programmed address region.
// - Flash write strobe asserts only during a write to the selected device.
// - Memory read strobe asserts only during a read of the selected device.
// - A 26-bit address is driven on the shared address bus for accesses.
// - Narrow data bus is sampled on reads and driven on writes.
// - A reset strap chooses narrow or wide data bus for boot accesses.
// - Each region select has a setting choosing narrow or wide data bus.
// - Narrow bus accesses support 8-bit and 16-bit memory widths.
// - Wide bus accesses support 8-bit, 16-bit and 32-bit memory widths.
// - Wide data bus is sampled on reads, driven on writes, shared with SDRAM.
// - Buffer output enable asserts for every access through this controller.
// - Each region select asserts for its software-programmed address region when no higher-priority select also decodes the access.
// - Region select pins default to region function unless general select chosen.
package rfc_pkg;
  localparam int ADDR_W = 26;
  localparam int NARROW_W = 16;
  localparam int WIDE_W = 32;
  // Fixed boot-vector decode window.
  localparam logic [ADDR_W-1:0] BOOT_LO = 26'h03FF000;
  localparam logic [ADDR_W-1:0] BOOT_HI = 26'h03FFFFF;
  // Memory width codes.
  localparam logic [1:0] WIDTH_8 = 2'h0;
  localparam logic [1:0] WIDTH_16 = 2'h1;
  localparam logic [1:0] WIDTH_32 = 2'h2;
  // Select identifiers.
  localparam logic [1:0] SEL_BOOT = 2'h0;
  localparam logic [1:0] SEL_R1 = 2'h1;
  localparam logic [1:0] SEL_R2 = 2'h2;
  // Strap level that routes boot accesses to the narrow bus.
  localparam logic STRAP_NARROW = 1'b1;
  // Strobe timing.
  localparam int CLK_NS = 50;
  localparam int STROBE_NS = 200;
  localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
  // Synchroniser depth that read data must settle through.
  localparam int SYNC_LAT = 3;
  typedef enum logic [1:0] {ST_IDLE, ST_SETUP, ST_STROBE, ST_HOLD} rfc_state_e;
endpackage

// ==== verilog/rfc_sync3.sv ====
// Three-stage pin synchroniser that reports when the last two stages agree.
`timescale 1ns/1ps
module rfc_sync3 #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [WIDTH-1:0] pin,
  output logic [WIDTH-1:0] value,
  output logic stable
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;
  logic [2:0] filled;

  // The first stage feeds only the second; agreement is judged on stages two and three.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
      filled <= 3'h0;
    end else begin
      stage1 <= pin;
      stage2 <= stage1;
      stage3 <= stage2;
      filled <= {filled[1:0], 1'b1};
    end
  end

  // Agreement counts only once every stage holds a sampled pin value, not its reset zero.
  assign value = stage3;
  assign stable = filled[2] && (stage2 == stage3);
endmodule // rfc_sync3

// ==== verilog/rfc_ctrl.sv ====
// ROM/Flash chip-select, strobe and data-bus pin controller.
`timescale 1ns/1ps
module rfc_ctrl #(
  parameter int STROBE_CYCLES = rfc_pkg::STROBE_CYC
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic access_req,
  input wire logic access_write,
  input wire logic [25:0] access_addr,
  input wire logic [31:0] access_wdata,
  output logic access_ready,
  output logic access_done,
  output logic access_error,
  output logic [31:0] access_rdata,
  input wire logic boot_region_en,
  input wire logic [25:0] boot_region_base,
  input wire logic [25:0] boot_region_mask,
  input wire logic [1:0] boot_width,
  input wire logic region1_en,
  input wire logic [25:0] region1_base,
  input wire logic [25:0] region1_mask,
  input wire logic region1_narrow,
  input wire logic [1:0] region1_width,
  input wire logic region2_en,
  input wire logic [25:0] region2_base,
  input wire logic [25:0] region2_mask,
  input wire logic region2_narrow,
  input wire logic [1:0] region2_width,
  input wire logic general_mode_1,
  input wire logic general_mode_2,
  input wire logic general_select_1_req,
  input wire logic general_select_2_req,
  input wire logic boot_bus_strap,
  output logic boot_select_n,
  output logic region_select_1_n,
  output logic region_select_2_n,
  output logic flash_write_strobe_n,
  output logic memory_read_strobe_n,
  output logic buffer_output_enable_n,
  output logic [25:0] shared_address_bus,
  input wire logic [15:0] narrow_data_in,
  output logic [15:0] narrow_data_out,
  output logic narrow_data_oe,
  input wire logic [31:0] wide_data_in,
  output logic [31:0] wide_data_out,
  output logic wide_data_oe
);
  localparam logic [7:0] STROBE_LAST = 8'(STROBE_CYCLES - 1);

  // Read data must settle through the synchroniser within the strobe.
  if (STROBE_CYCLES < rfc_pkg::SYNC_LAT + 1 || STROBE_CYCLES > 255) begin : g_bad_strobe
    $error("STROBE_CYCLES out of range");
  end

  rfc_pkg::rfc_state_e state, next_state;
  logic [7:0] cnt, next_cnt;
  logic [1:0] sel, next_sel;
  logic [1:0] width, next_width;
  logic is_write, next_is_write;
  logic is_narrow, next_is_narrow;
  logic cs_on, next_cs_on;
  logic strap_taken, next_strap_taken;
  logic boot_narrow, next_boot_narrow;
  logic next_ready, next_done, next_error;
  logic [31:0] next_rdata;
  logic next_boot_n, next_r1_n, next_r2_n, next_wr_n, next_rd_n, next_buf_n;
  logic [25:0] next_addr;
  logic [15:0] next_narrow_out;
  logic [31:0] next_wide_out;
  logic next_narrow_oe, next_wide_oe;
  logic strap_val, strap_stable, narrow_stable, wide_stable;
  logic [15:0] narrow_sync;
  logic [31:0] wide_sync;
  logic boot_fixed_hit, boot_prog_hit, r1_hit, r2_hit;
  logic [31:0] raw_rd, width_mask;

  // Pin inputs cross into the clock domain through three flops each.
  rfc_sync3 #(.WIDTH(1)) u_strap_sync (
    .clk(clk), .reset_n(reset_n), .pin(boot_bus_strap), .value(strap_val), .stable(strap_stable)
  );
  rfc_sync3 #(.WIDTH(16)) u_narrow_sync (
    .clk(clk), .reset_n(reset_n), .pin(narrow_data_in), .value(narrow_sync),
    .stable(narrow_stable)
  );
  rfc_sync3 #(.WIDTH(32)) u_wide_sync (
    .clk(clk), .reset_n(reset_n), .pin(wide_data_in), .value(wide_sync), .stable(wide_stable)
  );

  // Address decode of the fixed boot window and the programmed regions.
  assign boot_fixed_hit = (access_addr >= rfc_pkg::BOOT_LO) && (access_addr <= rfc_pkg::BOOT_HI);
  assign boot_prog_hit = boot_region_en && (((access_addr ^ boot_region_base) & boot_region_mask) == '0);
  assign r1_hit = region1_en && (((access_addr ^ region1_base) & region1_mask) == '0);
  assign r2_hit = region2_en && (((access_addr ^ region2_base) & region2_mask) == '0);

  // Read data source and mask for the latched bus and width.
  always_comb begin
    raw_rd = is_narrow ? {16'h0000, narrow_sync} : wide_sync;
    case (width)
      rfc_pkg::WIDTH_8: width_mask = 32'h000000FF;
      rfc_pkg::WIDTH_16: width_mask = 32'h0000FFFF;
      default: width_mask = 32'hFFFFFFFF;
    endcase
  end

  // Next-state logic of the access sequencer and the pins it drives.
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_sel = sel;
    next_width = width;
    next_is_write = is_write;
    next_is_narrow = is_narrow;
    next_cs_on = cs_on;
    next_strap_taken = strap_taken;
    next_boot_narrow = boot_narrow;
    next_ready = access_ready;
    next_done = 1'b0;
    next_error = 1'b0;
    next_rdata = access_rdata;
    next_wr_n = flash_write_strobe_n;
    next_rd_n = memory_read_strobe_n;
    next_addr = shared_address_bus;
    next_narrow_out = narrow_data_out;
    next_wide_out = wide_data_out;
    next_narrow_oe = narrow_data_oe;
    next_wide_oe = wide_data_oe;
    // The strap is caught once it has settled after reset release.
    if (!strap_taken && strap_stable) begin
      next_strap_taken = 1'b1;
      next_boot_narrow = (strap_val == rfc_pkg::STRAP_NARROW);
    end
    case (state)
      rfc_pkg::ST_IDLE: begin
        next_ready = strap_taken;
        if (access_req && access_ready) begin
          if (!(boot_fixed_hit || boot_prog_hit || r1_hit || r2_hit)) begin
            next_error = 1'b1;
          end else begin
            // Boot wins over region 1, region 1 over region 2, so one select only.
            if (boot_fixed_hit || boot_prog_hit) begin
              next_sel = rfc_pkg::SEL_BOOT;
              next_is_narrow = boot_narrow;
              next_width = boot_width;
            end else if (r1_hit) begin
              next_sel = rfc_pkg::SEL_R1;
              next_is_narrow = region1_narrow;
              next_width = region1_width;
            end else begin
              next_sel = rfc_pkg::SEL_R2;
              next_is_narrow = region2_narrow;
              next_width = region2_width;
            end
            // The narrow bus carries at most 16 bits.
            if (next_is_narrow && next_width == rfc_pkg::WIDTH_32) begin
              next_width = rfc_pkg::WIDTH_16;
            end else if (next_width > rfc_pkg::WIDTH_32) begin
              next_width = rfc_pkg::WIDTH_32;
            end
            next_is_write = access_write;
            next_cs_on = 1'b1;
            next_ready = 1'b0;
            next_addr = access_addr;
            next_narrow_out = access_wdata[15:0];
            next_wide_out = access_wdata;
            next_narrow_oe = access_write && next_is_narrow;
            next_wide_oe = access_write && !next_is_narrow;
            next_state = rfc_pkg::ST_SETUP;
          end
        end
      end
      rfc_pkg::ST_SETUP: begin
        next_wr_n = !is_write;
        next_rd_n = is_write;
        next_cnt = STROBE_LAST;
        next_state = rfc_pkg::ST_STROBE;
      end
      rfc_pkg::ST_STROBE: begin
        if (cnt != 8'h00) begin
          next_cnt = cnt - 8'h01;
        end else if (is_write || (is_narrow ? narrow_stable : wide_stable)) begin
          next_wr_n = 1'b1;
          next_rd_n = 1'b1;
          if (!is_write) begin
            next_rdata = raw_rd & width_mask;
          end
          next_state = rfc_pkg::ST_HOLD;
        end
      end
      rfc_pkg::ST_HOLD: begin
        next_cs_on = 1'b0;
        next_narrow_oe = 1'b0;
        next_wide_oe = 1'b0;
        next_done = 1'b1;
        next_ready = 1'b1;
        next_state = rfc_pkg::ST_IDLE;
      end
      default: begin
        next_state = rfc_pkg::ST_IDLE;
      end
    endcase
    // Select pins; the region pins carry the general selects only when chosen.
    next_buf_n = !next_cs_on;
    next_boot_n = !(next_cs_on && next_sel == rfc_pkg::SEL_BOOT);
    next_r1_n = general_mode_1 ? !general_select_1_req
                               : !(next_cs_on && next_sel == rfc_pkg::SEL_R1);
    next_r2_n = general_mode_2 ? !general_select_2_req
                               : !(next_cs_on && next_sel == rfc_pkg::SEL_R2);
  end

  // Registers of the sequencer; all pins come straight from here.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state <= rfc_pkg::ST_IDLE;
      cnt <= 8'h00;
      sel <= rfc_pkg::SEL_BOOT;
      width <= rfc_pkg::WIDTH_8;
      is_write <= 1'b0;
      is_narrow <= 1'b0;
      cs_on <= 1'b0;
      strap_taken <= 1'b0;
      boot_narrow <= 1'b0;
      access_ready <= 1'b0;
      access_done <= 1'b0;
      access_error <= 1'b0;
      access_rdata <= 32'h00000000;
      boot_select_n <= 1'b1;
      region_select_1_n <= 1'b1;
      region_select_2_n <= 1'b1;
      flash_write_strobe_n <= 1'b1;
      memory_read_strobe_n <= 1'b1;
      buffer_output_enable_n <= 1'b1;
      shared_address_bus <= 26'h0000000;
      narrow_data_out <= 16'h0000;
      narrow_data_oe <= 1'b0;
      wide_data_out <= 32'h00000000;
      wide_data_oe <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      sel <= next_sel;
      width <= next_width;
      is_write <= next_is_write;
      is_narrow <= next_is_narrow;
      cs_on <= next_cs_on;
      strap_taken <= next_strap_taken;
      boot_narrow <= next_boot_narrow;
      access_ready <= next_ready;
      access_done <= next_done;
      access_error <= next_error;
      access_rdata <= next_rdata;
      boot_select_n <= next_boot_n;
      region_select_1_n <= next_r1_n;
      region_select_2_n <= next_r2_n;
      flash_write_strobe_n <= next_wr_n;
      memory_read_strobe_n <= next_rd_n;
      buffer_output_enable_n <= next_buf_n;
      shared_address_bus <= next_addr;
      narrow_data_out <= next_narrow_out;
      narrow_data_oe <= next_narrow_oe;
      wide_data_out <= next_wide_out;
      wide_data_oe <= next_wide_oe;
    end
  end

  // Checks that tie the pins to the access that caused them.
  a_boot_decode: assert property (@(posedge clk) disable iff (!reset_n)
    (state == rfc_pkg::ST_IDLE && access_req && access_ready && boot_fixed_hit)
    |=> !boot_select_n [*3]) else $error("boot select missing for boot window");
  a_region1_hit: assert property (@(posedge clk) disable iff (!reset_n)
    (state == rfc_pkg::ST_IDLE && access_req && access_ready && !boot_fixed_hit &&
     !boot_prog_hit && r1_hit && !general_mode_1) |=> !region_select_1_n && boot_select_n)
    else $error("region 1 select missing");
  a_strobe_excl: assert property (@(posedge clk) disable iff (!reset_n)
    !(!flash_write_strobe_n && !memory_read_strobe_n)) else $error("both strobes active");
  a_one_select: assert property (@(posedge clk) disable iff (!reset_n)
    (!general_mode_1 && !general_mode_2) |-> $countones({!boot_select_n, !region_select_1_n,
    !region_select_2_n}) <= 1) else $error("more than one select active");
  a_write_strobe: assert property (@(posedge clk) disable iff (!reset_n)
    $fell(flash_write_strobe_n) |-> is_write && cs_on && $past(state) == rfc_pkg::ST_SETUP)
    else $error("write strobe outside a write");
  a_read_len: assert property (@(posedge clk) disable iff (!reset_n)
    $fell(memory_read_strobe_n) |-> !is_write ##0 !memory_read_strobe_n [*4])
    else $error("read strobe too short or on a write");
  a_buffer_enable: assert property (@(posedge clk) disable iff (!reset_n)
    (!flash_write_strobe_n || !memory_read_strobe_n) |-> !buffer_output_enable_n)
    else $error("buffer disabled during strobe");
  a_addr_stable: assert property (@(posedge clk) disable iff (!reset_n)
    (!flash_write_strobe_n || !memory_read_strobe_n) |-> $stable(shared_address_bus))
    else $error("address moved during strobe");
  a_narrow_drive: assert property (@(posedge clk) disable iff (!reset_n)
    narrow_data_oe |-> is_write && is_narrow && !wide_data_oe)
    else $error("narrow bus driven wrongly");
  a_wide_drive: assert property (@(posedge clk) disable iff (!reset_n)
    wide_data_oe |-> is_write && !is_narrow && cs_on) else $error("wide bus driven wrongly");
  a_done_follows: assert property (@(posedge clk) disable iff (!reset_n)
    access_done |-> buffer_output_enable_n && access_ready) else $error("done while busy");
endmodule // rfc_ctrl

// ==== tb/rfc_mem_model.sv ====
// Behavioural ROM/Flash memory that answers on whichever data bus wrote each word.
`timescale 1ns/1ps
module rfc_mem_model (
  input wire logic clk,
  input wire logic sel_boot_n,
  input wire logic sel_1_n,
  input wire logic sel_2_n,
  input wire logic write_n,
  input wire logic read_n,
  input wire logic [25:0] addr,
  input wire logic [15:0] nd_out,
  input wire logic nd_oe,
  input wire logic [31:0] wd_out,
  input wire logic wd_oe,
  output logic [15:0] narrow_data_in,
  output logic [31:0] wide_data_in,
  output logic [25:0] last_addr
);
  logic [31:0] mem [logic [25:0]];
  logic on_narrow [logic [25:0]];
  logic selected;
  logic driving = 1'b0;
  assign selected = !(sel_boot_n && sel_1_n && sel_2_n);
  initial begin
    narrow_data_in = 16'h5A5A;
    wide_data_in = 32'hA5A5_5A5A;
    last_addr = 26'h0;
  end
  // Capture data at the end of the write strobe, from the bus that drives it.
  always @(posedge write_n) begin
    if (selected === 1'b1) begin
      mem[addr] = nd_oe ? {16'h0, nd_out} : wd_out;
      on_narrow[addr] = nd_oe;
    end
  end
  // Record the address present when either strobe starts.
  always @(negedge write_n or negedge read_n) begin
    last_addr = addr;
  end
  // Drive read data on the owning bus; once released, the buses show the inverse of their value.
  always @(posedge clk) begin
    driving <= (read_n === 1'b0 && selected === 1'b1 && mem.exists(addr));
    if (read_n === 1'b0 && selected === 1'b1 && mem.exists(addr)) begin
      if (on_narrow[addr]) begin
        narrow_data_in <= mem[addr][15:0];
      end else begin
        wide_data_in <= mem[addr];
      end
    end else if (driving) begin
      narrow_data_in <= ~narrow_data_in;
      wide_data_in <= ~wide_data_in;
    end
  end
endmodule // rfc_mem_model

// ==== tb/rfc_ctrl_tb.sv ====
// Self-checking testbench for the ROM/Flash chip-select controller.
`timescale 1ns/1ps
module rfc_ctrl_tb;
  logic clk = 1'b0, reset_n = 1'b0, access_req = 1'b0, access_write = 1'b0;
  logic [25:0] access_addr = 26'h0, b_base = 26'h0100000, r1_base = 26'h0200000;
  logic [25:0] r2_base = 26'h0500000, b_mask = 26'h3F00000, r_mask = 26'h3F00000;
  logic [31:0] access_wdata = 32'h0, access_rdata, wide_data_in, wide_data_out;
  logic access_ready, access_done, access_error, boot_select_n, r1_n, r2_n, wr_n, rd_n;
  logic buf_n, narrow_data_oe, wide_data_oe, strap = 1'b1, b_en = 1'b1, r1_en = 1'b1;
  logic r1_nar = 1'b0, r2_nar = 1'b1, gm1 = 1'b0, gm2 = 1'b0, gs1 = 1'b0, gs2 = 1'b0;
  logic r2_en = 1'b1;
  logic [1:0] b_w = rfc_pkg::WIDTH_16, r1_w = rfc_pkg::WIDTH_32, r2_w = rfc_pkg::WIDTH_8;
  logic [25:0] shared_address_bus, last_addr;
  logic [15:0] narrow_data_in, narrow_data_out;
  logic [4:0] seen;
  int bad_count = 0, n_checks = 0, cycles = 0;
  rfc_ctrl u_rfc_ctrl (.clk(clk), .reset_n(reset_n), .access_req(access_req),
    .access_write(access_write), .access_addr(access_addr), .access_wdata(access_wdata),
    .access_ready(access_ready), .access_done(access_done), .access_error(access_error),
    .access_rdata(access_rdata), .boot_region_en(b_en), .boot_region_base(b_base),
    .boot_region_mask(b_mask), .boot_width(b_w), .region1_en(r1_en), .region1_base(r1_base),
    .region1_mask(r_mask), .region1_narrow(r1_nar), .region1_width(r1_w),
    .region2_en(r2_en), .region2_base(r2_base), .region2_mask(r_mask), .region2_narrow(r2_nar),
    .region2_width(r2_w), .general_mode_1(gm1), .general_mode_2(gm2),
    .general_select_1_req(gs1), .general_select_2_req(gs2), .boot_bus_strap(strap),
    .boot_select_n(boot_select_n), .region_select_1_n(r1_n), .region_select_2_n(r2_n),
    .flash_write_strobe_n(wr_n), .memory_read_strobe_n(rd_n),
    .buffer_output_enable_n(buf_n), .shared_address_bus(shared_address_bus),
    .narrow_data_in(narrow_data_in), .narrow_data_out(narrow_data_out),
    .narrow_data_oe(narrow_data_oe), .wide_data_in(wide_data_in),
    .wide_data_out(wide_data_out), .wide_data_oe(wide_data_oe));
  rfc_mem_model u_rfc_mem_model (.clk(clk), .sel_boot_n(boot_select_n), .sel_1_n(r1_n),
    .sel_2_n(r2_n), .write_n(wr_n), .read_n(rd_n), .addr(shared_address_bus),
    .nd_out(narrow_data_out), .nd_oe(narrow_data_oe), .wd_out(wide_data_out),
    .wd_oe(wide_data_oe), .narrow_data_in(narrow_data_in), .wide_data_in(wide_data_in),
    .last_addr(last_addr));
  // Clock generator.
  always #25 clk = ~clk;
  // Reports a mismatch between a seen and an expected value.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  // Records pin activity and watches for overlapping selects or strobes.
  always @(posedge clk) begin
    if (reset_n && !gm1 && !gm2) begin
      seen = seen | {wide_data_oe, narrow_data_oe, !r2_n, !r1_n, !boot_select_n};
      chk(32'(!boot_select_n + !r1_n + !r2_n) <= 1, 32'h1, "select overlap");
      chk(32'(!wr_n && !rd_n), 32'h0, "strobes together");
      chk(32'((!wr_n || !rd_n) && buf_n), 32'h0, "buffer off in strobe");
    end
    cycles++;
    if (cycles == 5000) begin
      bad_count++;
      complete_run();
    end
  end
  // Prints the counts and the verdict, then stops.
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Applies reset for ten cycles with the given strap and waits for readiness.
  task automatic do_reset(input logic s);
    @(posedge clk) #1 reset_n = 1'b0;
    strap = s;
    repeat (10) @(posedge clk);
    #1 reset_n = 1'b1;
    for (int n = 0; n < 50 && access_ready !== 1'b1; n++) @(posedge clk) #1;
    chk(access_ready, 1'b1, "ready after reset");
  endtask
  // Runs one access and compares completion, pins, address and read data.
  task automatic go(input logic w, input logic [25:0] a, input logic [31:0] d,
                    input logic e, input logic [31:0] q, input logic [4:0] s);
    int n;
    seen = 5'h0;
    for (n = 0; n < 50 && access_ready !== 1'b1; n++) @(posedge clk) #1;
    access_req = 1'b1;
    access_write = w;
    access_addr = a;
    access_wdata = d;
    @(posedge clk) #1 access_req = 1'b0;
    for (n = 0; n < 300 && access_done !== 1'b1 && access_error !== 1'b1; n++) @(posedge clk) #1;
    chk(32'(access_done || access_error), 32'h1, "access finished");
    chk(access_error, e, "error flag");
    chk(seen, s, "pins used");
    if (!e) chk(last_addr, a, "address");
    if (!e && !w) chk(access_rdata, q, "read data");
    @(posedge clk) #1;
  endtask
  // Boot window edges and narrow routing chosen by the strap.
  task automatic t_boot();
    go(1'b1, 26'h03FF000, 32'hDEAD_BEEF, 1'b0, 0, 5'h09);
    go(1'b0, 26'h03FF000, 0, 1'b0, 32'h0000_BEEF, 5'h01);
    go(1'b1, 26'h03FFFFF, 32'h1, 1'b0, 0, 5'h09);
    go(1'b0, 26'h03FEFFF, 0, 1'b1, 0, 5'h00);
    go(1'b1, 26'h0100010, 32'h0000_5678, 1'b0, 0, 5'h09);
    go(1'b0, 26'h0100010, 0, 1'b0, 32'h0000_5678, 5'h01);
    $display("test boot done");
  endtask
  // Region selects with wide 32-bit and narrow 8-bit memories, then disabled decodes.
  task automatic t_regions();
    go(1'b1, 26'h0200004, 32'hCAFE_F00D, 1'b0, 0, 5'h12);
    go(1'b0, 26'h0200004, 0, 1'b0, 32'hCAFE_F00D, 5'h02);
    go(1'b1, 26'h0500008, 32'hA5A5_1234, 1'b0, 0, 5'h0C);
    go(1'b0, 26'h0500008, 0, 1'b0, 32'h0000_0034, 5'h04);
    r1_en = 1'b0;
    r2_en = 1'b0;
    b_mask = 26'h3FFFFFF;
    go(1'b0, 26'h0200004, 0, 1'b1, 0, 5'h00);
    go(1'b0, 26'h0500008, 0, 1'b1, 0, 5'h00);
    go(1'b0, 26'h0100014, 0, 1'b1, 0, 5'h00);
    r1_en = 1'b1;
    r2_en = 1'b1;
    b_mask = 26'h3F00000;
    $display("test regions done");
  endtask
  // General select function on the region select pin and its default.
  task automatic t_general();
    chk(r1_n, 1'b1, "region pin idle");
    chk(r2_n, 1'b1, "region 2 pin idle");
    gm1 = 1'b1;
    gm2 = 1'b1;
    gs1 = 1'b1;
    repeat (2) @(posedge clk) #1;
    chk(r1_n, 1'b0, "general select on");
    chk(r2_n, 1'b1, "general select 2 off");
    gs1 = 1'b0;
    gs2 = 1'b1;
    repeat (2) @(posedge clk) #1;
    chk(r1_n, 1'b1, "general select off");
    chk(r2_n, 1'b0, "general select 2 on");
    gs2 = 1'b0;
    gm1 = 1'b0;
    gm2 = 1'b0;
    $display("test general done");
  endtask
  // Strap low routes boot accesses over the wide bus at 32 bits.
  task automatic t_strap_wide();
    b_w = rfc_pkg::WIDTH_32;
    do_reset(1'b0);
    go(1'b1, 26'h03FF010, 32'h1234_5678, 1'b0, 0, 5'h11);
    go(1'b0, 26'h03FF010, 0, 1'b0, 32'h1234_5678, 5'h01);
    $display("test strap wide done");
  endtask
  // Main sequence.
  initial begin
    do_reset(1'b1);
    t_boot();
    t_regions();
    t_general();
    t_strap_wide();
    complete_run();
  end
endmodule // rfc_ctrl_tb
